/* File: src/spec_checker.v */
// Serial port error checker: watches host frames on the serial
// register port and raises sticky error flags.
// Assumes a host master driving the serial clock, chip select low
// active and a data input; register decode done elsewhere via inputs.
`timescale 1ns/1ps
`include "spec_regs.vh"

module spec_checker
(
   input wire i_clk,
   input wire i_srst,
   // Serial pins, asynchronous to i_clk
   input wire i_sclk,
   input wire i_cs_n,
   input wire i_mosi,
   // Configuration
   input wire i_en_wr,
   input wire [7:0] i_en_data,
   input wire i_chip_select_enable,
   // Device state
   input wire i_fuse_copy,
   input wire i_calib_busy,
   input wire i_conv_fault,
   // Address qualifiers from the register map
   input wire i_addr_valid,
   input wire i_addr_readonly,
   input wire i_crc_ok,
   // Flag clear, one bit per flag
   input wire [5:0] i_flag_clr,
   output reg [7:0] o_err_en,
   output reg [5:0] o_err_flags,
   output reg o_wr_commit,
   output reg [6:0] o_wr_addr,
   output reg [7:0] o_wr_data
);

   // ----------------------------------------------------------------
   // Local state
   // ----------------------------------------------------------------
   localparam ST_IDLE = 3'b001;
   localparam ST_SHIFT = 3'b010;
   localparam ST_END = 3'b100;

   wire [2:0] pins_s;
   wire sclk_s;
   wire cs_n_s;
   wire mosi_s;
   reg sclk_d_ff;
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [`SPEC_CNT_W-1:0] cnt_ff;
   reg [15:0] shift_ff;
   reg [7:0] en_ff;
   reg [5:0] flg_ff;
   reg [5:0] nxt_flg;
   reg commit_ff;
   reg [6:0] addr_ff;
   reg [7:0] data_ff;
   wire sclk_rise;
   wire frame_end;
   wire is_read;
   wire cnt_active;
   wire whole_bytes;
   wire short_write;
   wire wr_accept;
   reg [5:0] ev;

   // Saturating add keeps long frames from wrapping into a false pass
   function [`SPEC_CNT_W-1:0] spec_inc;
      input [`SPEC_CNT_W-1:0] v;
      begin
         if (&v)
            spec_inc = v;
         else
            spec_inc = v + 1'b1;
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   // Chip select passes inverted so the synchroniser's reset level
   // reads as deselected; otherwise reset fakes an empty frame
   spec_sync #(.W(3)) u_sync
   (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_async({i_sclk, ~i_cs_n, i_mosi}),
      .o_sync(pins_s)
   );

   assign sclk_s = pins_s[2];
   assign cs_n_s = ~pins_s[1];
   assign mosi_s = pins_s[0];

   // Edge detect on the synchronised clock only
   always @(posedge i_clk)
   begin
      if (i_srst)
         sclk_d_ff <= 1'b0;
      else
         sclk_d_ff <= sclk_s;
   end

   assign sclk_rise = sclk_s & ~sclk_d_ff;

   // ----------------------------------------------------------------
   // Enable register
   // ----------------------------------------------------------------
   // Bit 6 on, all other checks off after reset
   always @(posedge i_clk)
   begin
      if (i_srst)
         en_ff <= `SPEC_EN_RESET;
      else if (i_en_wr)
         en_ff <= i_en_data;
   end

   // ----------------------------------------------------------------
   // Frame state machine
   // ----------------------------------------------------------------
   always @*
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:
         begin
            if (!cs_n_s)
               nxt_state = ST_SHIFT;
         end
         ST_SHIFT:
         begin
            if (cs_n_s)
               nxt_state = ST_END;
         end
         ST_END:
            nxt_state = ST_IDLE;
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   always @(posedge i_clk)
   begin
      if (i_srst)
         state_ff <= ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   // Clock counting and shifting inside the chip-select frame
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         cnt_ff <= {`SPEC_CNT_W{1'b0}};
         shift_ff <= 16'h0000;
      end
      else if (state_ff == ST_IDLE)
      begin
         cnt_ff <= {`SPEC_CNT_W{1'b0}};
         shift_ff <= 16'h0000;
      end
      else if (state_ff == ST_SHIFT && !cs_n_s && sclk_rise)
      begin
         cnt_ff <= spec_inc(cnt_ff);
         if (cnt_ff < `SPEC_FRAME_BITS)
            shift_ff <= {shift_ff[14:0], mosi_s};
      end
   end

   // ----------------------------------------------------------------
   // Frame decode
   // ----------------------------------------------------------------
   // First bit of frame is the read/write flag, then 7 address bits
   assign frame_end = (state_ff == ST_END);
   assign is_read = shift_ff[15];
   assign cnt_active = en_ff[`SPEC_EN_CNT_BIT] & i_chip_select_enable;
   assign whole_bytes = ((cnt_ff[2:0] & `SPEC_BYTE_BITS) == 3'h0);
   assign short_write = cnt_active && (cnt_ff < `SPEC_FRAME_BITS);

   // Error events for this cycle
   always @*
   begin
      ev = 6'h00;
      ev[`SPEC_FLG_CONV] = en_ff[`SPEC_EN_CONV_BIT] & i_conv_fault;
      ev[`SPEC_FLG_IGN] = frame_end & ~is_read & en_ff[`SPEC_EN_IGN_BIT]
                        & (i_fuse_copy | i_calib_busy);
      ev[`SPEC_FLG_CNT] = frame_end & cnt_active & ~whole_bytes;
      ev[`SPEC_FLG_RD] = frame_end & is_read & en_ff[`SPEC_EN_RD_BIT]
                       & i_chip_select_enable & ~i_addr_valid;
      ev[`SPEC_FLG_WR] = frame_end & ~is_read & en_ff[`SPEC_EN_WR_BIT]
                       & i_chip_select_enable
                       & (~i_addr_valid | i_addr_readonly);
      ev[`SPEC_FLG_CRC] = frame_end & ~is_read & en_ff[`SPEC_EN_CRC_BIT]
                        & ~i_crc_ok;
   end

   // Sticky flags; a new event beats a clear in the same cycle
   always @*
   begin
      nxt_flg = (flg_ff & ~i_flag_clr) | ev;
   end

   always @(posedge i_clk)
   begin
      if (i_srst)
         flg_ff <= 6'h00;
      else
         flg_ff <= nxt_flg;
   end

   // ----------------------------------------------------------------
   // Write commit
   // ----------------------------------------------------------------
   // Blocked writes never reach the register file
   assign wr_accept = frame_end & ~is_read & ~short_write
                    & ~(i_fuse_copy | i_calib_busy)
                    & i_addr_valid & ~i_addr_readonly
                    & (~en_ff[`SPEC_EN_CRC_BIT] | i_crc_ok);

   // Address and data keep the last accepted write, so an aborted
   // frame leaves them untouched
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         commit_ff <= 1'b0;
         addr_ff <= 7'h00;
         data_ff <= 8'h00;
      end
      else
      begin
         commit_ff <= wr_accept;
         if (wr_accept)
         begin
            addr_ff <= shift_ff[14:8];
            data_ff <= shift_ff[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always @*
   begin
      o_err_en = en_ff;
      o_err_flags = flg_ff;
      o_wr_commit = commit_ff;
      o_wr_addr = addr_ff;
      o_wr_data = data_ff;
   end

endmodule

/* File: shared/spec_regs.vh */
// Constants for the serial port error checker: enable bit positions,
// reset values and flag positions.
// Assumes inclusion by bare name from the design files.
`ifndef SPEC_REGS_VH
`define SPEC_REGS_VH

// ----------------------------------------------------------------
// Enable register bit positions
// ----------------------------------------------------------------
`define SPEC_EN_CONV_BIT 7
`define SPEC_EN_IGN_BIT 6
`define SPEC_EN_CNT_BIT 5
`define SPEC_EN_RD_BIT 4
`define SPEC_EN_WR_BIT 3
`define SPEC_EN_CRC_BIT 2
`define SPEC_EN_RESET 8'h40

// ----------------------------------------------------------------
// Error flag bit positions in o_err_flags
// ----------------------------------------------------------------
`define SPEC_FLG_CONV 0
`define SPEC_FLG_IGN 1
`define SPEC_FLG_CNT 2
`define SPEC_FLG_RD 3
`define SPEC_FLG_WR 4
`define SPEC_FLG_CRC 5
`define SPEC_FLG_W 6

// ----------------------------------------------------------------
// Frame format
// ----------------------------------------------------------------
`define SPEC_BYTE_BITS 3'h7
`define SPEC_FRAME_BITS 6'h10
`define SPEC_CNT_W 6

`endif

/* File: src/spec_sync.v */
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs come from outside the i_clk domain.
`timescale 1ns/1ps

module spec_sync
#(
   parameter W = 3
)
(
   input wire i_clk,
   input wire i_srst,
   input wire [W-1:0] i_async,
   output reg [W-1:0] o_sync
);

   reg [W-1:0] meta_ff;

   // First stage feeds only the second stage
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         meta_ff <= {W{1'b0}};
         o_sync <= {W{1'b0}};
      end
      else
      begin
         meta_ff <= i_async;
         o_sync <= meta_ff;
      end
   end

endmodule

/* File: testbench/spec_checker_monitor.sv */
// Port assertions for the serial error checker.
// Assumes a bind onto spec_checker; one clock.
`timescale 1ns/1ps
module spec_checker_monitor
(
   input wire i_clk,
   input wire i_srst,
   input wire i_chip_select_enable,
   input wire i_conv_fault,
   input wire i_fuse_copy,
   input wire i_calib_busy,
   input wire i_addr_valid,
   input wire i_addr_readonly,
   input wire i_crc_ok,
   input wire [5:0] i_flag_clr,
   input wire [7:0] o_err_en,
   input wire [5:0] o_err_flags,
   input wire o_wr_commit
);
   // -----------------
   // Flags and commits
   // -----------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   // A flag rises only from an enabled cause
   en_reset_a:
      assert property (disable iff (1'h0) i_srst |=> o_err_en == 8'h40) else $error("enable reset");
   conv_set_a:
      assert property (o_err_en[7] && i_conv_fault |=> o_err_flags[0]) else $error("conv flag");
   cnt_gate_a:
      assert property ($rose(o_err_flags[2]) |-> $past(o_err_en[5] && i_chip_select_enable)) else $error("count");
   rd_gate_a:
      assert property ($rose(o_err_flags[3]) |-> $past(o_err_en[4] && i_chip_select_enable && !i_addr_valid))
      else $error("read flag");
   wr_gate_a:
      assert property ($rose(o_err_flags[4]) |-> $past(o_err_en[3] && i_chip_select_enable
         && !(i_addr_valid && !i_addr_readonly))) else $error("write flag");
   crc_gate_a:
      assert property ($rose(o_err_flags[5]) |-> $past(o_err_en[2] && !i_crc_ok)) else $error("crc flag");
   // Past reset only, since the reset edge itself drops the flags
   flag_hold_a:
      assert property (!$past(i_srst) |-> ($past(o_err_flags & ~i_flag_clr) & ~o_err_flags) == 6'h00)
      else $error("flag lost");
   ign_gate_a:
      assert property ($rose(o_err_flags[1]) |-> $past(o_err_en[6] && (i_fuse_copy || i_calib_busy)))
      else $error("ignore flag");
   busy_block_a:
      assert property (o_wr_commit |-> $past(!(i_fuse_copy || i_calib_busy))) else $error("busy commit");
   commit_ok_a:
      assert property (o_wr_commit |-> $past(i_addr_valid && !i_addr_readonly && (i_crc_ok || !o_err_en[2])))
      else $error("bad commit");
   // Main scenarios reached
   cover property (o_wr_commit);
   cover property ($rose(o_err_flags[2]));
   cover property ($rose(o_err_flags[1]));
endmodule
bind spec_checker spec_checker_monitor mon
(
   .i_clk(i_clk),
   .i_srst(i_srst),
   .i_chip_select_enable(i_chip_select_enable),
   .i_conv_fault(i_conv_fault),
   .i_fuse_copy(i_fuse_copy),
   .i_calib_busy(i_calib_busy),
   .i_addr_valid(i_addr_valid),
   .i_addr_readonly(i_addr_readonly),
   .i_crc_ok(i_crc_ok),
   .i_flag_clr(i_flag_clr),
   .o_err_en(o_err_en),
   .o_err_flags(o_err_flags),
   .o_wr_commit(o_wr_commit)
);

/* File: testbench/spec_host.sv */
// Host serial master model for the checker pins.
// Assumes the caller keeps frames apart.
`timescale 1ns/1ps
module spec_host
(
   output reg o_sclk = 1'h0,
   output reg o_cs_n = 1'h1,
   output reg o_mosi = 1'h0
);
   // -----------
   // Frame drive
   // -----------
   // Clock runs only inside frames, 200 ns period
   task automatic xfer(input int n, input logic [15:0] w);
      o_cs_n = 1'h0;
      for (int i = 0; i < n; i++)
      begin
         o_mosi = (i < 16) ? w[15 - i] : ~o_mosi;
         #100 o_sclk = 1'h1;
         #100 o_sclk = 1'h0;
      end
      #100 o_cs_n = 1'h1;
      o_mosi = ~o_mosi; // No stale data after release
      #300;
   endtask
endmodule

/* File: testbench/tb.sv */
// Bench for the serial error checker, host model on the pins.
// Assumes the monitor binds itself onto uut.
`timescale 1ns/1ps
module tb;
   // -------------
   // Bench signals
   // -------------
   logic i_clk = 1'h0, i_srst = 1'h1, i_en_wr = 1'h0, i_chip_select_enable = 1'h1, i_fuse_copy = 1'h0;
   logic i_calib_busy = 1'h0, i_conv_fault = 1'h0, i_addr_valid = 1'h1, i_addr_readonly = 1'h0, i_crc_ok = 1'h1;
   logic [7:0] i_en_data = 8'h00;
   logic [5:0] i_flag_clr = 6'h00;
   wire i_sclk, i_cs_n, i_mosi, o_wr_commit;
   wire [7:0] o_err_en, o_wr_data;
   wire [5:0] o_err_flags;
   wire [6:0] o_wr_addr;
   int failures = 0, checked = 0, commits = 0, cycles = 0;
   spec_host host (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_mosi(i_mosi));
   spec_checker uut
   (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_sclk(i_sclk),
      .i_cs_n(i_cs_n),
      .i_mosi(i_mosi),
      .i_en_wr(i_en_wr),
      .i_en_data(i_en_data),
      .i_chip_select_enable(i_chip_select_enable),
      .i_fuse_copy(i_fuse_copy),
      .i_calib_busy(i_calib_busy),
      .i_conv_fault(i_conv_fault),
      .i_addr_valid(i_addr_valid),
      .i_addr_readonly(i_addr_readonly),
      .i_crc_ok(i_crc_ok),
      .i_flag_clr(i_flag_clr),
      .o_err_en(o_err_en),
      .o_err_flags(o_err_flags),
      .o_wr_commit(o_wr_commit),
      .o_wr_addr(o_wr_addr),
      .o_wr_data(o_wr_data)
   );
   // Free-running 40 MHz clock
   initial
   begin
      forever #12.5 i_clk = ~i_clk;
   end
   // Commits counted here; the ceiling cuts a hang short
   always @(posedge i_clk)
   begin
      cycles++;
      commits += (o_wr_commit === 1'h1);
      if (cycles == 20000)
      begin
         failures++;
         wrap_up();
      end
   end
   // ---------------
   // Checks, frames
   // ---------------
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   // Frame, settle, judge, then clear so frames stay independent
   task frame(input int n, input logic [15:0] w, input logic [5:0] f, input int c);
      commits = 0;
      host.xfer(n, w);
      repeat (10) @(negedge i_clk);
      chk(16'(o_err_flags), 16'(f));
      chk(16'(commits), 16'(c));
      i_flag_clr = 6'h3F;
      @(negedge i_clk) i_flag_clr = 6'h00;
   endtask
   task set_en(input logic [7:0] e);
      i_en_data = e;
      i_en_wr = 1'h1;
      @(negedge i_clk) i_en_wr = 1'h0;
   endtask
   task t_count;
      set_en(8'h7C);
      frame(16, 16'h12A5, 6'h00, 1);
      chk(16'({o_wr_addr, o_wr_data}), 16'h12A5);
      frame(12, 16'h12A5, 6'h04, 0);
      chk(16'({o_wr_addr, o_wr_data}), 16'h12A5);
      frame(24, 16'h92A5, 6'h00, 0);
      host.xfer(12, 16'h12A5);
      frame(16, 16'h1234, 6'h04, 1);
      i_chip_select_enable = 1'h0;
      frame(12, 16'h12A5, 6'h00, 1);
      i_chip_select_enable = 1'h1;
   endtask
   task t_addr;
      i_addr_valid = 1'h0;
      frame(16, 16'h9200, 6'h08, 0);
      frame(16, 16'h12A5, 6'h10, 0);
      i_addr_valid = 1'h1;
      i_addr_readonly = 1'h1;
      frame(16, 16'h12A5, 6'h10, 0);
      i_addr_readonly = 1'h0;
   endtask
   task t_guard;
      i_crc_ok = 1'h0;
      frame(16, 16'h12A5, 6'h20, 0);
      set_en(8'h78);
      frame(16, 16'h12A5, 6'h00, 1);
      chk(16'({o_wr_addr, o_wr_data}), 16'h12A5);
      i_crc_ok = 1'h1;
      i_fuse_copy = 1'h1;
      frame(16, 16'h12A5, 6'h02, 0);
      set_en(8'h38);
      frame(16, 16'h12A5, 6'h00, 0);
      i_fuse_copy = 1'h0;
      i_calib_busy = 1'h1;
      set_en(8'h78);
      frame(16, 16'h12A5, 6'h02, 0);
      i_calib_busy = 1'h0;
   endtask
   task t_conv;
      for (int k = 0; k < 2; k++)
      begin
         set_en(k ? 8'hF8 : 8'h78);
         i_conv_fault = 1'h1;
         @(negedge i_clk) i_conv_fault = 1'h0;
         @(negedge i_clk);
         chk(16'(o_err_flags), 16'(k));
      end
   endtask
   task wrap_up;
      $display("Checks %0d, failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Reset for two cycles, synchroniser settles, then the scenarios
   initial
   begin
      repeat (2) @(negedge i_clk);
      i_srst = 1'h0;
      repeat (8) @(negedge i_clk);
      chk(16'(o_err_en), 16'h0040);
      chk(16'(commits), 16'h0000);
      t_count();
      t_addr();
      t_guard();
      t_conv();
      wrap_up();
   end
endmodule
